// *** rtl/skw_seeded_key_watchdog.v ***
`timescale 1ns/1ps
`include "skw_regs.vh"
module skw_seeded_key_watchdog #(
  parameter TIMEOUT_CYC = `SKW_TIMEOUT_CYC,
  parameter RST_CYC     = `SKW_RST_CYC,
  parameter FAST_CYC    = `SKW_FAST_RST_CYC,
  parameter SEED_DIV    = `SKW_SEED_DIV
) (
  input  wire       ref_clk_in,
  input  wire       resetn_in,
  input  wire       sm_resetn_in,
  input  wire       disable_in,
  input  wire       key_submit_in,
  input  wire [7:0] key_data_in,
  input  wire       seed_read_in,
  input  wire       test_entry_in,
  input  wire       retry_clear_in,
  input  wire       fast_wd_reset_in,
  input  wire [7:0] retry_max_in,
  output reg  [7:0] seed_out,
  output reg  [7:0] prev_key_out,
  output reg        seed_valid_out,
  output wire       qualified_error_reset_flag_out,
  output wire       test_indicator_out,
  output wire       lockout_flag_out,
  output wire       disable_pin_status_bit_out,
  output wire       reset_pin_out,
  output wire       wd_error_out,
  output wire [2:0] state_out,
  output wire [7:0] retry_count_out,
  output wire [7:0] error_tally_out
);
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [17:0] tmr_reg;
  reg [15:0] div_reg;
  reg [7:0]  seed_cnt_reg;
  reg [7:0]  key_reg;
  reg [7:0]  prev_key_reg;
  reg [7:0]  seed_reg;
  reg [7:0]  retry_reg;
  reg [7:0]  tally_reg;
  reg        wdr_reg;
  reg        lock_reg;
  reg        err_pulse_reg;
  reg        dis_s1_reg;
  reg        dis_reg;
  wire       sm_active;
  wire       timing;
  wire       expired;
  wire       key_ok;
  wire       key_good;
  wire       slow_busy;
  wire       fast_busy;
  wire       enter_reset;
  wire [7:0] new_key;
  wire       seed_wait_entry;
  wire       key_latch;
  wire       retries_done;
  wire       enter_test;
  wire       qual_fail;
  wire       tally_full;

  assign sm_active = sm_resetn_in;
  assign timing    = (state_reg == `SKW_ST_SEEDWAIT) ||
                     (state_reg == `SKW_ST_RUN) ||
                     (state_reg == `SKW_ST_TEST) ||
                     (state_reg == `SKW_ST_QUAL);
  assign expired   = timing && !dis_reg &&
                     (tmr_reg == TIMEOUT_CYC[17:0]);
  assign key_ok    = key_submit_in && (key_data_in == key_reg);
  assign key_good  = key_ok && timing && !expired;
  // next key from freshly latched seed
  assign new_key   = (seed_cnt_reg ^ key_reg) + `SKW_KEY_INC;

  // default key taken in the initial state
  assign seed_wait_entry = (state_reg == `SKW_ST_INIT) &&
                           (state_next == `SKW_ST_SEEDWAIT);
  // seed-wait entry latches like a correct key
  assign key_latch       = !dis_reg && (key_good || seed_wait_entry);
  // permitted retries used up
  assign retries_done    = (retry_reg >= retry_max_in);
  // last cycle before the test state, as the move into it is taken
  assign enter_test      = (state_next == `SKW_ST_TEST) &&
                           (state_reg != `SKW_ST_TEST);
  // qualified failure, not a test expiry
  assign qual_fail       = enter_reset && (state_reg == `SKW_ST_QUAL);
  // tally stops at its top value
  assign tally_full      = (tally_reg == 8'hff);

  // disable pin, two stage sample
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dis_s1_reg <= 1'b0;
      dis_reg    <= 1'b0;
    end else begin
      dis_s1_reg <= disable_in;
      dis_reg    <= dis_s1_reg;
    end
  end
  assign disable_pin_status_bit_out = dis_reg;

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_reg      <= 16'h0000;
      seed_cnt_reg <= `SKW_SEED_RST;
    end else if (!sm_active) begin
      div_reg      <= 16'h0000;
      seed_cnt_reg <= `SKW_SEED_RST;
    end else if (div_reg == SEED_DIV[15:0] - 16'h0001) begin
      div_reg      <= 16'h0000;
      seed_cnt_reg <= seed_cnt_reg + 8'h01;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `SKW_ST_INIT: begin
        if (test_entry_in) begin
          state_next = `SKW_ST_OVERRIDE;
        end else if (key_submit_in && key_data_in == `SKW_DEFAULT_KEY) begin
          state_next = `SKW_ST_SEEDWAIT;
        end
      end
      `SKW_ST_OVERRIDE: state_next = `SKW_ST_OVERRIDE;
      `SKW_ST_SEEDWAIT, `SKW_ST_RUN: begin
        if (test_entry_in) begin
          state_next = `SKW_ST_TEST;
        end else if (expired) begin
          state_next = `SKW_ST_QUAL;
        end else if (key_good) begin
          state_next = `SKW_ST_RUN;
        end
      end
      `SKW_ST_TEST: begin
        if (expired) begin
          state_next = `SKW_ST_RESET;
        end else if (key_good) begin
          state_next = `SKW_ST_RUN;
        end
      end
      `SKW_ST_QUAL: begin
        if (key_good) begin
          state_next = `SKW_ST_RUN;
        end else if (expired && retries_done) begin
          state_next = `SKW_ST_RESET;
        end
      end
      `SKW_ST_RESET: begin
        if (!slow_busy && !err_pulse_reg) begin
          state_next = `SKW_ST_INIT;
        end
      end
      default: state_next = `SKW_ST_INIT;
    endcase
  end

  assign enter_reset = (state_next == `SKW_ST_RESET) &&
                       (state_reg != `SKW_ST_RESET);

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg     <= `SKW_ST_INIT;
      tmr_reg       <= 18'h00000;
      err_pulse_reg <= 1'b0;
    end else if (!sm_active) begin
      state_reg     <= `SKW_ST_INIT;
      tmr_reg       <= 18'h00000;
      err_pulse_reg <= 1'b0;
    end else begin
      state_reg     <= dis_reg ? state_reg : state_next;
      err_pulse_reg <= expired;
      if (dis_reg || !timing) begin
        tmr_reg <= 18'h00000;
      end else if (key_good || expired) begin
        tmr_reg <= 18'h00000;
      end else begin
        tmr_reg <= tmr_reg + 18'h00001;
      end
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seed_reg     <= `SKW_SEED_RST;
      key_reg      <= `SKW_DEFAULT_KEY;
      prev_key_reg <= `SKW_DEFAULT_KEY;
    end else if (!sm_active) begin
      seed_reg     <= `SKW_SEED_RST;
      key_reg      <= `SKW_DEFAULT_KEY;
      prev_key_reg <= `SKW_DEFAULT_KEY;
    end else if (key_latch) begin
      seed_reg     <= seed_cnt_reg;
      prev_key_reg <= key_reg;
      key_reg      <= new_key;
    end
  end

  // seed read returns seed and previous key
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seed_out       <= 8'h00;
      prev_key_out   <= 8'h00;
      seed_valid_out <= 1'b0;
    end else if (!sm_active) begin
      seed_valid_out <= 1'b0;
    end else begin
      seed_valid_out <= seed_read_in;
      if (seed_read_in) begin
        seed_out     <= seed_reg;
        prev_key_out <= prev_key_reg;
      end
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      retry_reg <= 8'h00;
    end else if (!sm_active) begin
      retry_reg <= 8'h00;
    end else if (retry_clear_in) begin
      retry_reg <= 8'h00;
    end else if (expired && state_reg == `SKW_ST_QUAL) begin
      retry_reg <= retry_reg + 8'h01;
    end
  end

  // error tally, kept across machine reset
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tally_reg <= 8'h00;
    end else if (sm_active && expired && !tally_full) begin
      tally_reg <= tally_reg + 8'h01;
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wdr_reg <= 1'b0;
    end else if (!sm_active) begin
      wdr_reg <= 1'b0;
    end else if (expired && enter_reset &&
                 (state_reg == `SKW_ST_QUAL ||
                  state_reg == `SKW_ST_TEST)) begin
      wdr_reg <= 1'b1;
    end
  end

  // lockout set on qualified error, cleared on a good key into run or on entering test
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lock_reg <= 1'b1;
    end else if (!sm_active) begin
      lock_reg <= 1'b1;
    end else if (qual_fail) begin
      lock_reg <= 1'b1;
    end else if (enter_test && !dis_reg) begin
      lock_reg <= 1'b0;
    end else if (state_next == `SKW_ST_RUN && key_good && !dis_reg) begin
      lock_reg <= 1'b0;
    end
  end

  skw_pulse_timer #(
    .W   (16),
    .CNT (RST_CYC)
  ) u_slow (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .start_in   (enter_reset),
    .busy_out   (slow_busy)
  );

  skw_pulse_timer #(
    .W   (16),
    .CNT (FAST_CYC)
  ) u_fast (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .start_in   (fast_wd_reset_in),
    .busy_out   (fast_busy)
  );

  assign reset_pin_out = fast_busy ||
                         (slow_busy && wdr_reg && lock_reg);
  assign qualified_error_reset_flag_out = wdr_reg;
  assign test_indicator_out = (state_reg == `SKW_ST_TEST);
  assign lockout_flag_out   = lock_reg;
  assign wd_error_out       = err_pulse_reg;
  assign state_out          = state_reg;
  assign retry_count_out    = retry_reg;
  assign error_tally_out    = tally_reg;
endmodule

// *** rtl/skw_regs.vh ***
`ifndef SKW_REGS_VH
`define SKW_REGS_VH
// clock and times
`define SKW_CLK_HZ        10000000
`define SKW_RST_TIME_US   1000
`define SKW_RST_CYC       ((`SKW_RST_TIME_US * (`SKW_CLK_HZ / 1000000)))
`define SKW_FAST_RST_US   1000
`define SKW_FAST_RST_CYC  ((`SKW_FAST_RST_US * (`SKW_CLK_HZ / 1000000)))
`define SKW_TIMEOUT_CYC   50000
`define SKW_SEED_DIV      16
`define SKW_RETRY_MAX     8'h02
// key and seed
`define SKW_KEY_W         8
`define SKW_DEFAULT_KEY   8'h00
`define SKW_KEY_INC       8'h01
`define SKW_SEED_RST      8'h00
// states
`define SKW_ST_INIT       3'h0
`define SKW_ST_OVERRIDE   3'h1
`define SKW_ST_SEEDWAIT   3'h2
`define SKW_ST_RUN        3'h3
`define SKW_ST_TEST       3'h4
`define SKW_ST_QUAL       3'h5
`define SKW_ST_RESET      3'h6
`endif

// *** rtl/skw_pulse_timer.v ***
`timescale 1ns/1ps
// holds busy high for a fixed count after start
module skw_pulse_timer #(
  parameter W   = 16,
  parameter CNT = 10000
) (
  input  wire         ref_clk_in,
  input  wire         resetn_in,
  input  wire         start_in,
  output wire         busy_out
);
  reg [W-1:0] cnt_reg;

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg <= {W{1'b0}};
    end else if (start_in) begin
      cnt_reg <= CNT[W-1:0];
    end else if (cnt_reg != {W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy_out = (cnt_reg != {W{1'b0}});
endmodule

// *** bench/skw_host_model.sv ***
`timescale 1ns/1ps
module skw_host_model (
  input  wire       ref_clk_in,
  input  wire       seed_valid_in,
  input  wire [7:0] seed_in,
  input  wire [7:0] prev_key_in,
  output reg  [7:0] key_out
);
  initial key_out = 8'h00;
  always @(posedge ref_clk_in) begin
    if (seed_valid_in)
      key_out <= (seed_in ^ prev_key_in) + 8'h01;
  end
endmodule

// *** bench/skw_check_monitor.sv ***
`timescale 1ns/1ps
module skw_check_monitor (
  input wire       ref_clk_in,
  input wire       resetn_in,
  input wire       sm_resetn_in,
  input wire       key_submit_in,
  input wire [7:0] key_data_in,
  input wire       retry_clear_in,
  input wire       qualified_error_reset_flag_out,
  input wire       test_indicator_out,
  input wire       lockout_flag_out,
  input wire       disable_pin_status_bit_out,
  input wire       reset_pin_out,
  input wire       wd_error_out,
  input wire [2:0] state_out,
  input wire [7:0] retry_count_out,
  input wire [7:0] error_tally_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  wire take = sm_resetn_in && !disable_pin_status_bit_out;
  a_test_flag: assert property (
    test_indicator_out == (state_out == 3'h4)) else $error("test flag");
  a_test_quiet: assert property (
    state_out == 3'h4 |-> !lockout_flag_out && !reset_pin_out)
    else $error("test state not quiet");
  a_retry_zero: assert property (
    retry_clear_in && take |=> retry_count_out == 8'h00)
    else $error("retry not cleared");
  a_machine_reset: assert property (
    !sm_resetn_in |=> state_out == 3'h0 && lockout_flag_out &&
    !qualified_error_reset_flag_out) else $error("machine reset");
  a_tally_step: assert property (
    $past(sm_resetn_in) && sm_resetn_in && $changed(error_tally_out) |->
    error_tally_out == $past(error_tally_out) + 8'h01)
    else $error("tally step");
  a_flag_hold: assert property (
    qualified_error_reset_flag_out && sm_resetn_in |=>
    qualified_error_reset_flag_out) else $error("flag lost");
  a_disabled_quiet: assert property (
    disable_pin_status_bit_out && $past(disable_pin_status_bit_out) |->
    !wd_error_out) else $error("error while disabled");
  a_default_key: assert property (
    state_out == 3'h0 && key_submit_in && key_data_in == 8'h00 && take
    |=> state_out == 3'h2) else $error("default key");
  c_run: cover property (state_out == 3'h3);
  c_test: cover property (state_out == 3'h4);
  c_reset: cover property (state_out == 3'h6 && reset_pin_out);
endmodule
bind skw_seeded_key_watchdog skw_check_monitor i_skw_check_monitor (
  .ref_clk_in, .resetn_in, .sm_resetn_in, .key_submit_in, .key_data_in,
  .retry_clear_in, .qualified_error_reset_flag_out, .test_indicator_out,
  .lockout_flag_out, .disable_pin_status_bit_out, .reset_pin_out,
  .wd_error_out, .state_out, .retry_count_out, .error_tally_out);

// *** bench/skw_seeded_key_watchdog_test.sv ***
`timescale 1ns/1ps
module skw_seeded_key_watchdog_test;
  reg        ref_clk_in = 1'b0;
  reg        resetn_in = 1'b0;
  reg        sm_resetn_in = 1'b1;
  reg        disable_in = 1'b0;
  reg  [4:0] cm = 5'h00;
  reg  [7:0] key_data_in = 8'h00;
  reg  [7:0] pk = 8'h00;
  wire       key_submit_in, seed_read_in, test_entry_in, retry_clear_in;
  wire       fast_wd_reset_in, seed_valid_out, qualified_error_reset_flag_out;
  wire       test_indicator_out, lockout_flag_out, disable_pin_status_bit_out;
  wire       reset_pin_out, wd_error_out;
  wire [7:0] seed_out, prev_key_out, retry_count_out, error_tally_out, key;
  wire [2:0] state_out;
  wire [7:0] st = {5'h00, state_out};
  integer    num_errors = 0, total_checks = 0, n_err = 0, n_pin = 0, c, i;
  reg [15:0] rows [0:3];
  assign {key_submit_in, seed_read_in, test_entry_in, retry_clear_in,
    fast_wd_reset_in} = cm;
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    if (wd_error_out === 1'b1) n_err = n_err + 1;
    if (reset_pin_out === 1'b1) n_pin = n_pin + 1;
  end
  skw_seeded_key_watchdog #(.TIMEOUT_CYC(50), .RST_CYC(20), .FAST_CYC(20),
    .SEED_DIV(2)) i_skw_seeded_key_watchdog (.ref_clk_in, .resetn_in,
    .sm_resetn_in, .disable_in, .key_submit_in, .key_data_in, .seed_read_in,
    .test_entry_in, .retry_clear_in, .fast_wd_reset_in, .retry_max_in(8'h02),
    .seed_out, .prev_key_out, .seed_valid_out, .qualified_error_reset_flag_out,
    .test_indicator_out, .lockout_flag_out, .disable_pin_status_bit_out,
    .reset_pin_out, .wd_error_out, .state_out, .retry_count_out,
    .error_tally_out);
  skw_host_model i_skw_host_model (.ref_clk_in, .seed_valid_in(seed_valid_out),
    .seed_in(seed_out), .prev_key_in(prev_key_out), .key_out(key));
  task tick(input integer n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task chk8(input [8*6-1:0] nm, input [7:0] e, input [7:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input [8*6-1:0] nm, input e, input g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // one command pulse, then a cycle for the answer
  task cmd(input [4:0] m, input [7:0] d);
    cm = m;
    key_data_in = d;
    tick(1);
    cm = 5'h00;
    tick(1);
  endtask
  task service;
    cmd(5'h08, 8'h00);
    cmd(5'h10, key);
  endtask
  task smr;
    sm_resetn_in = 1'b0;
    tick(2);
    sm_resetn_in = 1'b1;
    tick(1);
  endtask
  task wait_st(input [7:0] s, input integer lim);
    integer k;
    for (k = 0; k < lim && st !== s; k = k + 1) tick(1);
    chk8("state", s, st);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #3000000;
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial begin
    rows[0] = 16'h0003;
    rows[1] = 16'h0303;
    rows[2] = 16'h2803;
    rows[3] = 16'h2803;
    tick(10);
    resetn_in = 1'b1;
    tick(1);
    chk8("state", 8'h00, st);
    chk1("lock", 1'b1, lockout_flag_out);
    cmd(5'h04, 8'h00);
    chk8("state", 8'h01, st);
    smr;
    chk8("state", 8'h00, st);
    cmd(5'h10, 8'h00);
    chk8("state", 8'h02, st);
    $display("start test done");
    disable_in = 1'b1;
    c = n_err;
    tick(80);
    chk1("dis", 1'b1, disable_pin_status_bit_out);
    chk8("err", 8'h00, 8'(n_err - c));
    disable_in = 1'b0;
    tick(3);
    service;
    chk8("state", 8'h03, st);
    chk1("lock", 1'b0, lockout_flag_out);
    c = n_err;
    for (i = 0; i < 4; i = i + 1) begin
      tick(rows[i][15:8]);
      pk = key;
      service;
      chk8("state", rows[i][7:0], st);
      chk8("pkey", pk, prev_key_out);
    end
    chk8("err", 8'h00, 8'(n_err - c));
    $display("service test done");
    cmd(5'h04, 8'h00);
    chk8("state", 8'h04, st);
    chk1("tind", 1'b1, test_indicator_out);
    c = n_pin;
    wait_st(8'h06, 80);
    chk1("flag", 1'b1, qualified_error_reset_flag_out);
    chk1("lock", 1'b0, lockout_flag_out);
    tick(30);
    chk8("pin", 8'h00, 8'(n_pin - c));
    $display("test mode done");
    smr;
    cmd(5'h10, 8'h00);
    service;
    tick(30);
    cmd(5'h08, 8'h00);
    c = n_err;
    cmd(5'h10, key ^ 8'h01);
    wait_st(8'h05, 25);
    tick(1);
    chk8("err", 8'h01, 8'(n_err - c));
    chk8("tally", 8'h02, error_tally_out);
    cmd(5'h02, 8'h00);
    chk8("retry", 8'h00, retry_count_out);
    wait_st(8'h06, 300);
    chk1("flag", 1'b1, qualified_error_reset_flag_out);
    chk1("lock", 1'b1, lockout_flag_out);
    c = n_pin;
    wait_st(8'h00, 40);
    chk8("pin", 8'd20, 8'(n_pin - c));
    chk1("flag", 1'b1, qualified_error_reset_flag_out);
    c = n_pin;
    cmd(5'h01, 8'h00);
    tick(30);
    chk8("pin", 8'd20, 8'(n_pin - c));
    $display("fault test done");
    print_verdict;
  end
endmodule
